// file: rtl/digital_output_timing_controller.sv
// digital output controller: register file, flash base, failure actions
// assumes an Avalon-MM master on clk and asynchronous failure pins
//
// Behaviour
// - A forced channel holds its forced level and ignores commands.
// - Force is set per channel; retention is the system's storage.
// - All flashing channels share one flash phase.
// - Flash half-period is 10 ms to 655,350 ms in 10 ms steps.
// - Flashing is on for the setting, off for the setting.
// - Each channel has on and off times, 0..655,350 ms by 10 ms.
// - Both times zero: channel follows commands directly.
// - Only on time: each ON command gives one pulse of on time.
// - ON during a pulse restarts the pulse from full length.
// - Only off time: ON waits the off time, then stays until OFF.
// - Both times: cycle on/off while commanded ON.
// - Holdoff keeps the channel off after turn-off despite ON.
// - Channel off longer than holdoff turns on with no delay; here that holds once off for holdoff + 1 s.
// - Holdoff timers restart at power-up; here they reload the reset holdoff of 0, so none runs.
// - Holdoff is 0..65535 s in 1 s steps.
// - Per-channel failure action: hold, off or on.
// - Failure detection enabled per communication port.
// - After recovery outputs keep failure states until rewritten.
//
// Design decisions made here: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
module digital_output_timing_controller
  import dout_pkg::*;
#(
  parameter int TICK_CYCLES_P = TICK_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // avalon-mm slave
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // communication failure flags, one per port
  input wire logic [NPORT-1:0] commFail,
  // output drivers
  output logic [NCH-1:0] doutOn
);
  logic tick10;
  logic tick1s;
  logic [NCH-1:0] cmd;
  logic [NCH-1:0] cmdStb;
  logic [15:0] flashTime;
  logic [15:0] flashCnt;
  logic flashPhase;
  logic [NPORT-1:0] failEn;
  logic [NPORT-1:0] failSync1;
  logic [NPORT-1:0] failSync2;
  logic failActive;
  logic failPrev;
  logic [15:0] onTime [NCH];
  logic [15:0] offTime [NCH];
  logic [15:0] holdoff [NCH];
  logic [CFG_W-1:0] cfg [NCH];
  logic [NCH-1:0] holdActive;
  logic [NCH-1:0] chanOut;
  logic [31:0] next_readdata;
  wire logic req = read || write;
  wire logic accept = req && !waitrequest;
  wire logic wrAcc = write && !waitrequest;
  wire logic [1:0] chIdx = address[3:2];
  wire logic [1:0] field = address[1:0];
  wire logic failRise = failActive && !failPrev;
  wire logic cmdWr = wrAcc && address == ADDR_CMD && byteenable[0];

  // fail action of one channel; the spare code 3 falls through as hold
  function automatic fail_act_t failAction(input logic [CFG_W-1:0] c);
    return fail_act_t'(c[CFG_FAIL_LSB +: 2]);
  endfunction

  time_base #(
    .TICK_CYCLES_P(TICK_CYCLES_P)
  ) u_time_base (
    .clk(clk),
    .resetn(resetn),
    .tick10(tick10),
    .tick1s(tick1s)
  );

  for (genvar i = 0; i < NCH; i++) begin : g_ch
    output_channel u_ch (
      .clk(clk),
      .resetn(resetn),
      .tick10(tick10),
      .tick1s(tick1s),
      .flashPhase(flashPhase),
      .cmd(cmd[i]),
      .cmdStb(cmdStb[i]),
      .onTime(onTime[i]),
      .offTime(offTime[i]),
      .holdoff(holdoff[i]),
      .cfg(cfg[i]),
      .out(chanOut[i]),
      .holdActive(holdActive[i])
    );
  end
  // channel outputs are already flip-flops
  assign doutOn = chanOut;

  // one wait cycle per access; read data latched in that cycle
  always_ff @(posedge clk) begin
    if (!resetn) begin
      waitrequest <= 1'b1;
    end else begin
      waitrequest <= !(req && waitrequest);
    end
  end

  always_comb begin
    next_readdata = 32'h00000000;
    if (isChanAddr(address)) begin
      unique case (field)
        CH_ON: next_readdata[15:0] = onTime[chIdx];
        CH_OFF: next_readdata[15:0] = offTime[chIdx];
        CH_HOLD: next_readdata[15:0] = holdoff[chIdx];
        CH_CFG: next_readdata[CFG_W-1:0] = cfg[chIdx];
      endcase
    end else if (address == ADDR_CMD) begin
      next_readdata[NCH-1:0] = cmd;
    end else if (address == ADDR_FLASH) begin
      next_readdata[15:0] = flashTime;
    end else if (address == ADDR_FAILEN) begin
      next_readdata[NPORT-1:0] = failEn;
    end else if (address == ADDR_STATUS) begin
      next_readdata[NCH-1:0] = chanOut;
      next_readdata[ST_HOLD_LSB +: NCH] = holdActive;
      next_readdata[ST_FAIL] = failActive;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      readdata <= 32'h00000000;
    end else if (read && waitrequest) begin
      readdata <= next_readdata;
    end
  end

  // global settings
  always_ff @(posedge clk) begin
    if (!resetn) begin
      flashTime <= FLASH_RST;
      failEn <= '0;
    end else if (wrAcc) begin
      if (address == ADDR_FLASH)
        flashTime <= mergeBe(flashTime, writedata, byteenable);
      if (address == ADDR_FAILEN && byteenable[0])
        failEn <= writedata[NPORT-1:0];
    end
  end

  // per-channel settings; force lives here and is restored by software
  always_ff @(posedge clk) begin
    if (!resetn) begin
      for (int i = 0; i < NCH; i++) begin
        onTime[i] <= TIME_RST;
        offTime[i] <= TIME_RST;
        holdoff[i] <= TIME_RST;
        cfg[i] <= CFG_RST;
      end
    end else if (wrAcc && isChanAddr(address)) begin
      unique case (field)
        CH_ON: onTime[chIdx] <= mergeBe(onTime[chIdx], writedata,
                                        byteenable);
        CH_OFF: offTime[chIdx] <= mergeBe(offTime[chIdx], writedata,
                                          byteenable);
        CH_HOLD: holdoff[chIdx] <= mergeBe(holdoff[chIdx], writedata,
                                           byteenable);
        CH_CFG: if (byteenable[0])
          cfg[chIdx] <= writedata[CFG_W-1:0];
      endcase
    end
  end

  // failure pins are asynchronous; only the second stage feeds logic
  always_ff @(posedge clk) begin
    if (!resetn) begin
      failSync1 <= '0;
      failSync2 <= '0;
      failActive <= 1'b0;
      failPrev <= 1'b0;
    end else begin
      failSync1 <= commFail;
      failSync2 <= failSync1;
      failActive <= |(failSync2 & failEn);
      failPrev <= failActive;
    end
  end

  // action on failure onset only; recovery leaves cmd alone
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cmd <= '0;
      cmdStb <= '0;
    end else begin
      cmdStb <= '0;
      if (cmdWr) begin
        cmd <= writedata[NCH-1:0];
        cmdStb <= '1;
      end
      if (failRise) begin
        for (int i = 0; i < NCH; i++) begin
          if (failAction(cfg[i]) == FAIL_OFF) begin
            cmd[i] <= 1'b0;
            cmdStb[i] <= 1'b1;
          end else if (failAction(cfg[i]) == FAIL_ON) begin
            cmd[i] <= 1'b1;
            cmdStb[i] <= 1'b1;
          end
        end
      end
    end
  end

  // one shared phase keeps every flashing channel in step
  always_ff @(posedge clk) begin
    if (!resetn) begin
      flashCnt <= 16'h0000;
      flashPhase <= 1'b0;
    end else if (tick10) begin
      if (flashCnt + 16'h0001 >= flashTime) begin
        flashCnt <= 16'h0000;
        flashPhase <= !flashPhase;
      end else begin
        flashCnt <= flashCnt + 16'h0001;
      end
    end
  end

  default clocking @(posedge clk);
  endclocking
  default disable iff (!resetn);

  sequence reqSeen;
    req && waitrequest;
  endsequence
  sequence ackGiven;
    !waitrequest ##1 waitrequest;
  endsequence

  bus_ack_a: assert property (reqSeen |=> ackGiven)
    else $error("access not acknowledged after one wait cycle");
  bus_idle_a: assert property (!req |=> waitrequest)
    else $error("wait request low without access");
  cmd_write_a: assert property (
    (wrAcc && address == ADDR_CMD && byteenable[0] && !failRise)
    |=> cmd == $past(writedata[NCH-1:0]) && cmdStb == '1)
    else $error("command write lost");
  fail_off_a: assert property (
    (failRise && cfg[0][CFG_FAIL_LSB +: 2] == FAIL_OFF)
    |=> !cmd[0] && cmdStb[0])
    else $error("failure off action not applied");
  fail_on_a: assert property (
    (failRise && cfg[0][CFG_FAIL_LSB +: 2] == FAIL_ON)
    |=> cmd[0] && cmdStb[0])
    else $error("failure on action not applied");
  fail_hold_a: assert property (
    (failRise && cfg[0][CFG_FAIL_LSB +: 2] == FAIL_HOLD
     && !(wrAcc && address == ADDR_CMD)) |=> $stable(cmd[0]))
    else $error("failure hold action changed command");
  recover_keep_a: assert property (
    ($fell(failActive) && !$past(cmdWr) && !$past(failRise))
    |-> cmd == $past(cmd))
    else $error("commands restored on recovery");
  fail_mask_a: assert property (
    (failEn == '0) |=> !failActive)
    else $error("failure seen on disabled port");
  flash_step_a: assert property (
    (tick10 && flashCnt + 16'h0001 >= flashTime)
    |=> flashPhase != $past(flashPhase) && flashCnt == 16'h0000)
    else $error("flash phase not toggled at half period");
  flash_hold_a: assert property (!tick10 |=> $stable(flashPhase))
    else $error("flash phase moved between ticks");
  status_read_a: assert property (
    (read && waitrequest && address == ADDR_STATUS)
    |=> readdata[NCH-1:0] == $past(chanOut)
        && readdata[ST_FAIL] == $past(failActive))
    else $error("status read wrong");

  // register writes take effect at the acknowledging edge
  flash_land_a: assert property (
    (wrAcc && address == ADDR_FLASH && byteenable == 4'h3)
    |=> flashTime == $past(writedata[15:0]))
    else $error("flash setting write lost");
  time_land_a: assert property (
    (wrAcc && isChanAddr(address) && field == CH_ON
     && byteenable[1:0] == 2'h3)
    |=> onTime[$past(chIdx)] == $past(writedata[15:0]))
    else $error("on time write lost");
  hold_land_a: assert property (
    (wrAcc && isChanAddr(address) && field == CH_HOLD
     && byteenable[1:0] == 2'h3)
    |=> holdoff[$past(chIdx)] == $past(writedata[15:0]))
    else $error("holdoff write lost");
  cfg_land_a: assert property (
    (wrAcc && isChanAddr(address) && field == CH_CFG && byteenable[0])
    |=> cfg[$past(chIdx)] == $past(writedata[CFG_W-1:0]))
    else $error("channel config write lost");
  // unmapped words are refused silently
  unmapped_a: assert property (
    (wrAcc && !isChanAddr(address) && address > ADDR_STATUS)
    |=> $stable(flashTime) && $stable(failEn))
    else $error("write to unmapped word changed a setting");

  // read data stands until the next read is seen in its wait cycle
  read_hold_a: assert property (
    !(read && waitrequest) |=> $stable(readdata))
    else $error("read data moved without a read");
  flash_read_a: assert property (
    (read && waitrequest && address == ADDR_FLASH)
    |=> readdata == {16'h0000, $past(flashTime)})
    else $error("flash setting read wrong");
  cfg_read_a: assert property (
    (read && waitrequest && isChanAddr(address) && field == CH_CFG)
    |=> readdata[CFG_W-1:0] == $past(cfg[chIdx]))
    else $error("channel config read wrong");
  status_hold_a: assert property (
    (read && waitrequest && address == ADDR_STATUS)
    |=> readdata[ST_HOLD_LSB +: NCH] == $past(holdActive))
    else $error("status holdoff bits wrong");

  // a command is one strobe; a lasting failure does not act again
  stb_pulse_a: assert property (
    (!cmdWr && !failRise) |=> cmdStb == '0)
    else $error("command strobe longer than one cycle");
  fail_once_a: assert property (
    (failActive && failPrev && !cmdWr) |=> $stable(cmd))
    else $error("failure action repeated while failure lasts");
  for (genvar i = 0; i < NCH; i++) begin : g_fail_chk
    fail_each_off_a: assert property (
      (failRise && failAction(cfg[i]) == FAIL_OFF) |=> !cmd[i])
      else $error("failure off action missed");
    fail_each_on_a: assert property (
      (failRise && failAction(cfg[i]) == FAIL_ON) |=> cmd[i])
      else $error("failure on action missed");
  end
endmodule

// file: include/dout_pkg.sv
// constants, field layout and types for the digital output controller
// assumes a 50 MHz system clock and word addressing on the register bus
package dout_pkg;
  localparam int NCH = 4;
  localparam int NPORT = 3;
  localparam int CLK_HZ = 50_000_000;
  localparam int TICK_MS = 10;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int TICKS_PER_SEC = 1000 / TICK_MS;
  // word addresses
  localparam logic [5:0] ADDR_CMD = 6'h00;
  localparam logic [5:0] ADDR_FLASH = 6'h01;
  localparam logic [5:0] ADDR_FAILEN = 6'h02;
  localparam logic [5:0] ADDR_STATUS = 6'h03;
  localparam logic [1:0] CH_BLOCK = 2'h1;
  localparam logic [1:0] CH_ON = 2'h0;
  localparam logic [1:0] CH_OFF = 2'h1;
  localparam logic [1:0] CH_HOLD = 2'h2;
  localparam logic [1:0] CH_CFG = 2'h3;
  // channel config bits
  localparam int CFG_FORCE_EN = 0;
  localparam int CFG_FORCE_VAL = 1;
  localparam int CFG_FLASH = 2;
  localparam int CFG_FAIL_LSB = 3;
  localparam int CFG_W = 5;
  // status bits
  localparam int ST_HOLD_LSB = 4;
  localparam int ST_FAIL = 8;
  // reset values
  localparam logic [15:0] FLASH_RST = 16'h0032;
  localparam logic [15:0] TIME_RST = 16'h0000;
  localparam logic [CFG_W-1:0] CFG_RST = 5'h00;
  typedef enum logic [1:0] {
    FAIL_HOLD = 2'h0,
    FAIL_OFF = 2'h1,
    FAIL_ON = 2'h2
  } fail_act_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DELAY = 2'b01,
    ST_RUN_ON = 2'b11,
    ST_RUN_OFF = 2'b10
  } chan_state_t;
  function automatic logic isChanAddr(input logic [5:0] a);
    return a[5:4] == CH_BLOCK;
  endfunction
  function automatic logic [15:0] mergeBe(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] be);
    return {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction
endpackage

// file: rtl/time_base.sv
// 10 ms and 1 s tick generator
// assumes the system clock; ticks are one-cycle pulses
`timescale 1ns/1ps
module time_base
  import dout_pkg::*;
#(
  parameter int TICK_CYCLES_P = TICK_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // ticks
  output logic tick10,
  output logic tick1s
);
  logic [19:0] div;
  logic [6:0] secCnt;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      div <= 20'h00000;
      tick10 <= 1'b0;
    end else if (div == 20'(TICK_CYCLES_P - 1)) begin
      div <= 20'h00000;
      tick10 <= 1'b1;
    end else begin
      div <= div + 20'h00001;
      tick10 <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      secCnt <= 7'h00;
      tick1s <= 1'b0;
    end else if (tick10 && secCnt == 7'(TICKS_PER_SEC - 1)) begin
      secCnt <= 7'h00;
      tick1s <= 1'b1;
    end else begin
      if (tick10) secCnt <= secCnt + 7'h01;
      tick1s <= 1'b0;
    end
  end

  sec_follows_a: assert property (@(posedge clk) disable iff (!resetn)
    tick1s |-> $past(tick10))
    else $error("second tick without a 10 ms tick");
endmodule

// file: rtl/output_channel.sv
// one output channel: timing modes, flashing, holdoff and forcing
// assumes shared ticks and flash phase from the top level
`timescale 1ns/1ps
module output_channel
  import dout_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // shared time bases
  input wire logic tick10,
  input wire logic tick1s,
  input wire logic flashPhase,
  // command
  input wire logic cmd,
  input wire logic cmdStb,
  // settings
  input wire logic [15:0] onTime,
  input wire logic [15:0] offTime,
  input wire logic [15:0] holdoff,
  input wire logic [CFG_W-1:0] cfg,
  // state
  output logic out,
  output logic holdActive
);
  chan_state_t state;
  logic [15:0] cnt;
  logic [16:0] holdCnt;
  logic holdStart;
  logic req;
  logic next_out;
  wire logic onZero = onTime == 16'h0000;
  wire logic offZero = offTime == 16'h0000;
  wire logic onCmd = cmdStb && cmd;
  wire logic done = cnt == 16'h0000;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state <= ST_IDLE;
      cnt <= 16'h0000;
    end else if (onZero && offZero) begin
      state <= ST_IDLE;
    end else begin
      if (tick10 && !done) cnt <= cnt - 16'h0001;
      unique case (state)
        ST_IDLE: if (onCmd && !onZero) begin
          state <= ST_RUN_ON; cnt <= onTime;
        end else if (onCmd) begin
          state <= ST_DELAY; cnt <= offTime;
        end
        ST_DELAY: if (cmdStb && !cmd) state <= ST_IDLE;
          else if (done) state <= ST_RUN_ON;
        ST_RUN_ON: if (offZero && onCmd) cnt <= onTime;
          else if (!offZero && !cmd) state <= ST_IDLE;
          else if (!onZero && done && offZero) state <= ST_IDLE;
          else if (!onZero && done) begin
            state <= ST_RUN_OFF; cnt <= offTime;
          end
        ST_RUN_OFF: if (!cmd) state <= ST_IDLE;
          else if (done) begin
            state <= ST_RUN_ON; cnt <= onTime;
          end
      endcase
    end
  end

  always_comb begin
    req = (onZero && offZero) ? cmd : (state == ST_RUN_ON);
    if (cfg[CFG_FLASH]) req = req && flashPhase;
    next_out = req && !holdActive;
    if (cfg[CFG_FORCE_EN]) next_out = cfg[CFG_FORCE_VAL];
  end
  assign holdActive = holdCnt != 17'h00000;

  // +1 second: the free-running tick may come early, so never short
  always_ff @(posedge clk) begin
    if (!resetn) begin
      holdCnt <= 17'h00000;
      holdStart <= 1'b1;
      out <= 1'b0;
    end else begin
      holdStart <= 1'b0;
      out <= next_out;
      if (holdStart || (out && !next_out))
        holdCnt <= holdoff == 16'h0000 ? 17'h00000
                   : {1'b0, holdoff} + 17'h00001;
      else if (tick1s && holdActive)
        holdCnt <= holdCnt - 17'h00001;
    end
  end

  force_hold_a: assert property (@(posedge clk) disable iff (!resetn)
    cfg[CFG_FORCE_EN] |=> out == $past(cfg[CFG_FORCE_VAL]))
    else $error("forced channel left its forced level");
  holdoff_off_a: assert property (@(posedge clk) disable iff (!resetn)
    (holdActive && !cfg[CFG_FORCE_EN]) |=> !out)
    else $error("output on during holdoff");
  holdoff_load_a: assert property (@(posedge clk) disable iff (!resetn)
    ($fell(out) && $past(holdoff) != 16'h0000)
    |-> holdCnt == {1'b0, $past(holdoff)} + 17'h00001)
    else $error("holdoff not restarted at turn-off");
  retrigger_a: assert property (@(posedge clk) disable iff (!resetn)
    (state == ST_RUN_ON && offZero && !onZero && onCmd)
    |=> cnt == $past(onTime))
    else $error("one-shot not retriggered");
  direct_a: assert property (@(posedge clk) disable iff (!resetn)
    (onZero && offZero && !holdActive && cfg == CFG_RST)
    |=> out == $past(cmd))
    else $error("untimed channel does not follow command");
endmodule

// file: tb/host_model.sv
// host side model: avalon-mm master doing single word accesses
// assumes callers enter xfer just after a rising clock edge
`timescale 1ns/1ps
module host_model (
  // clock
  input wire logic clk,
  // avalon-mm master
  output logic [5:0] address,
  output logic read,
  output logic write,
  output logic [31:0] writedata,
  output logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest
);
  initial begin
    address = 6'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h00000000;
    byteenable = 4'h3;
  end

  // request held until waitrequest is seen low at an edge
  // no cycle budget here: the bench's own limit ends a hang
  task automatic xfer(input logic w, input logic [5:0] a,
                      input logic [15:0] d, output logic [31:0] q);
    address <= a;
    writedata <= {16'h0000, d};
    write <= w;
    read <= ~w;
    @(posedge clk);
    while (waitrequest !== 1'b0) @(posedge clk);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask
endmodule

// file: tb/tb_top.sv
// self-checking bench for the digital output controller
// assumes a shortened tick: 10 cycles per 10 ms, 1000 per second
`timescale 1ns/1ps
`define CHK(g, e) begin \
  total_checks++; \
  if ((g) !== (e)) begin \
    errors++; \
    $display("BAD %0t got %h exp %h", $time, (g), (e)); \
  end \
end
module tb_top import dout_pkg::*;;
  localparam int TCK = 10;
  localparam int LIMIT = 20000;
  typedef struct packed {
    logic [5:0] a;
    logic [15:0] d;
    logic [31:0] e;
  } row_t;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [2:0] commFail = 3'b000;
  logic [5:0] address;
  logic read;
  logic write;
  logic [31:0] writedata;
  logic [3:0] byteenable;
  logic [31:0] readdata;
  logic waitrequest;
  logic [NCH-1:0] doutOn;
  logic [31:0] q;
  int errors = 0;
  int total_checks = 0;
  int cyc = 0;
  int n;
  // extremes of each field but off time; cfg row avoids force so no holdoff starts
  row_t rows [7] = '{'{6'h10, 16'hFFFF, 32'hFFFF},
    '{6'h11, 16'h1234, 32'h1234}, '{6'h12, 16'hFFFF, 32'hFFFF},
    '{6'h13, 16'hFFFE, 32'h1E}, '{ADDR_FLASH, 16'h0001, 32'h1},
    '{ADDR_FAILEN, 16'hFFFF, 32'h7}, '{6'h3F, 16'hAAAA, 32'h0}};

  always #10 clk = ~clk;

  digital_output_timing_controller #(.TICK_CYCLES_P(TCK)) DUT (
    .clk(clk), .resetn(resetn), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest),
    .commFail(commFail), .doutOn(doutOn));

  host_model host (
    .clk(clk), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest));

  task automatic final_report();
    if (errors == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    logic [31:0] t;
    host.xfer(1'b1, a, d, t);
  endtask

  task automatic rd(input logic [5:0] a);
    host.xfer(1'b0, a, 16'h0000, q);
  endtask

  task automatic waitv(input int ch, input logic v, input int m);
    n = 0;
    while (doutOn[ch] !== v && n < m) begin
      @(posedge clk);
      n++;
    end
  endtask

  task automatic rng(input int lo, input int hi);
    `CHK(n >= lo && n <= hi, 1'b1)
  endtask

  function automatic logic [5:0] ca(input int ch, input int k);
    return 6'h10 + 6'(4 * ch + k);
  endfunction

  always @(posedge clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      errors++;
      final_report();
    end
  end

  initial begin
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rd(ca(1, 3));
    `CHK(q, 32'h0)
    rd(ADDR_FLASH);
    `CHK(q, 32'h32)
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a);
      `CHK(q, rows[i].e)
    end
    for (int k = 0; k < 4; k++) wr(ca(0, k), 16'h0000);
    wr(ADDR_FAILEN, 16'h0000);
    // untimed channel follows commands
    wr(ADDR_CMD, 16'h0001);
    repeat (3) @(posedge clk);
    `CHK(doutOn, 4'h1)
    wr(ADDR_CMD, 16'h0000);
    repeat (3) @(posedge clk);
    `CHK(doutOn, 4'h0)
    // forcing on channel 1
    wr(ca(1, 3), 16'h0003);
    repeat (3) @(posedge clk);
    `CHK(doutOn[1], 1'b1)
    wr(ca(1, 3), 16'h0001);
    wr(ADDR_CMD, 16'h0002);
    repeat (3) @(posedge clk);
    `CHK(doutOn[1], 1'b0)
    wr(ca(1, 3), 16'h0000);
    wr(ADDR_CMD, 16'h0000);
    // one-shot, refire and retrigger on channel 0
    wr(ca(0, 0), 16'h0003);
    wr(ADDR_CMD, 16'h0001);
    waitv(0, 1'b1, 20);
    waitv(0, 1'b0, 60);
    rng(18, 32);
    wr(ADDR_CMD, 16'h0001);
    waitv(0, 1'b1, 20);
    rng(0, 10);
    repeat (15) @(posedge clk);
    wr(ADDR_CMD, 16'h0001);
    waitv(0, 1'b0, 60);
    rng(17, 40);
    wr(ca(0, 0), 16'h0000);
    wr(ADDR_CMD, 16'h0000);
    // delayed turn-on on channel 2
    wr(ca(2, 1), 16'h0004);
    wr(ADDR_CMD, 16'h0004);
    waitv(2, 1'b1, 80);
    rng(27, 45);
    repeat (60) @(posedge clk);
    `CHK(doutOn[2], 1'b1)
    wr(ADDR_CMD, 16'h0000);
    repeat (3) @(posedge clk);
    `CHK(doutOn[2], 1'b0)
    wr(ca(2, 1), 16'h0000);
    // cycling on channel 3
    wr(ca(3, 0), 16'h0002);
    wr(ca(3, 1), 16'h0003);
    wr(ADDR_CMD, 16'h0008);
    waitv(3, 1'b1, 60);
    waitv(3, 1'b0, 40);
    rng(9, 22);
    waitv(3, 1'b1, 50);
    rng(19, 32);
    wr(ADDR_CMD, 16'h0000);
    wr(ca(3, 0), 16'h0000);
    wr(ca(3, 1), 16'h0000);
    // two flashing channels share one phase
    wr(ADDR_FLASH, 16'h0002);
    wr(ca(0, 3), 16'h0004);
    wr(ca(1, 3), 16'h0004);
    wr(ADDR_CMD, 16'h0003);
    for (int k = 0; k < 60; k++) begin
      @(posedge clk);
      `CHK(doutOn[1], doutOn[0])
    end
    waitv(0, 1'b0, 40);
    waitv(0, 1'b1, 40);
    rng(18, 22);
    waitv(0, 1'b0, 40);
    rng(18, 22);
    wr(ADDR_CMD, 16'h0000);
    wr(ca(0, 3), 16'h0000);
    wr(ca(1, 3), 16'h0000);
    // holdoff of 1 s on channel 0; loads one extra second at most
    wr(ca(0, 2), 16'h0001);
    wr(ADDR_CMD, 16'h0001);
    repeat (3) @(posedge clk);
    `CHK(doutOn[0], 1'b1)
    wr(ADDR_CMD, 16'h0000);
    wr(ADDR_CMD, 16'h0001);
    rd(ADDR_STATUS);
    `CHK(q[4], 1'b1)
    waitv(0, 1'b1, 2500);
    rng(900, 2100);
    wr(ADDR_CMD, 16'h0000);
    repeat (2100) @(posedge clk);
    wr(ADDR_CMD, 16'h0001);
    repeat (3) @(posedge clk);
    `CHK(doutOn[0], 1'b1)
    wr(ADDR_CMD, 16'h0000);
    // failure actions: ch1 off, ch2 on, ch3 hold; only port 0 enabled
    wr(ADDR_FAILEN, 16'h0001);
    wr(ca(1, 3), 16'h0008);
    wr(ca(2, 3), 16'h0010);
    wr(ADDR_CMD, 16'h000A);
    commFail <= 3'b010;
    repeat (10) @(posedge clk);
    `CHK(doutOn, 4'hA)
    commFail <= 3'b011;
    repeat (10) @(posedge clk);
    `CHK(doutOn, 4'hC)
    commFail <= 3'b000;
    repeat (10) @(posedge clk);
    `CHK(doutOn, 4'hC)
    wr(ADDR_CMD, 16'h0002);
    repeat (3) @(posedge clk);
    `CHK(doutOn, 4'h2)
    // mid-run reset: outputs low, bus idle, settings back to defaults
    resetn <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK(doutOn, 4'h0)
    `CHK(waitrequest, 1'b1)
    resetn <= 1'b1;
    @(posedge clk);
    rd(ca(1, 3));
    `CHK(q, 32'h0)
    rd(ADDR_FLASH);
    `CHK(q, 32'h32)
    final_report();
  end
endmodule
